/* File: pkg/i2cbl_pkg.sv */
// Purpose: Shared constants and types of the two-wire boot loader.
// Assumes: A 100 MHz system clock.
// Notes:   Identity defaults live as parameters of the top module.
`default_nettype none
package i2cbl_pkg;
   localparam int CLK_HZ       = 100_000_000;
   localparam int RATE_STD_HZ  = 100_000;
   localparam int RATE_FAST_HZ = 400_000;
   // A quarter bit rounds up so the bus never runs above its rate.
   localparam int QTR_STD  = (CLK_HZ + 4 * RATE_STD_HZ - 1)
                             / (4 * RATE_STD_HZ);
   localparam int QTR_FAST = (CLK_HZ + 4 * RATE_FAST_HZ - 1)
                             / (4 * RATE_FAST_HZ);
   localparam int QTR_W    = 9;

   localparam logic [7:0] SIG_IDS   = 8'hC0;
   localparam logic [7:0] SIG_IMAGE = 8'hC2;
   localparam logic [7:0] DEV_WRITE = 8'hA0;
   localparam logic [7:0] DEV_READ  = 8'hA1;
   localparam logic [7:0] MEM_ADDR_HI = 8'h00;
   localparam logic [7:0] MEM_ADDR_LO = 8'h00;

   localparam logic [15:0] IDX_SIG    = 16'h0000;
   localparam logic [15:0] IDX_VID_LO = 16'h0001;
   localparam logic [15:0] IDX_VID_HI = 16'h0002;
   localparam logic [15:0] IDX_PID_LO = 16'h0003;
   localparam logic [15:0] IDX_PID_HI = 16'h0004;
   localparam logic [15:0] IDX_DID_LO = 16'h0005;
   localparam logic [15:0] IDX_DID_HI = 16'h0006;
   localparam logic [15:0] IDX_CFG    = 16'h0007;
   localparam int          END_MARK_BIT = 7;

   localparam int RAM_AW = 14;

   typedef enum logic [1:0] {
      I2CBL_CMD_START,
      I2CBL_CMD_STOP,
      I2CBL_CMD_WRITE,
      I2CBL_CMD_READ
   } i2cbl_cmd_type;

   typedef enum logic [1:0] {
      I2CBL_SRC_NONE,
      I2CBL_SRC_IDS,
      I2CBL_SRC_IMAGE
   } i2cbl_src_type;
endpackage
`default_nettype wire

/* File: rtl/i2cbl_bit_engine.sv */
// Purpose: Two-wire master bit engine: start, stop, byte write, byte read.
// Assumes: Open-drain pins; an enable high pulls the wire low.
// Notes:   Each bit is four quarters; a stretched clock stalls the count.
`default_nettype none
module i2cbl_bit_engine
(
   input  wire logic                 clk,
   input  wire logic                 resetn,
   input  wire logic                 cmdValid,
   input  wire i2cbl_pkg::i2cbl_cmd_type cmd,
   input  wire logic [7:0]           txByte,
   input  wire logic                 ackOut,
   input  wire logic                 fastMode,
   input  wire logic                 sclIn,
   input  wire logic                 sdaIn,
   output logic                      sclOe,
   output logic                      sdaOe,
   output logic                      busy,
   output logic                      done,
   output logic [7:0]                rxByte,
   output logic                      ackIn
);
   typedef enum logic [1:0] {
      ENG_IDLE,
      ENG_START,
      ENG_BIT,
      ENG_STOP
   } i2cbl_eng_state_type;

   typedef struct packed {
      i2cbl_eng_state_type          st;
      logic [i2cbl_pkg::QTR_W-1:0]  qcnt;
      logic [1:0]                   ph;
      logic [3:0]                   bitN;
      logic [8:0]                   sh;
      logic                         sclLow;
      logic                         sdaLow;
      logic                         done;
      logic [7:0]                   rx;
      logic                         ack;
      logic                         fast;
      logic [1:0]                   sclS;
      logic [1:0]                   sdaS;
   } i2cbl_eng_type;

   i2cbl_eng_type eng_r;
   i2cbl_eng_type eng_nxt;

   localparam logic [i2cbl_pkg::QTR_W-1:0] QMAX_STD =
      i2cbl_pkg::QTR_W'(i2cbl_pkg::QTR_STD - 1);
   localparam logic [i2cbl_pkg::QTR_W-1:0] QMAX_FAST =
      i2cbl_pkg::QTR_W'(i2cbl_pkg::QTR_FAST - 1);

   always_comb
   begin
      logic tick;
      logic stall;
      tick  = 1'b0;
      stall = 1'b0;
      eng_nxt      = eng_r;
      eng_nxt.done = 1'b0;
      eng_nxt.sclS = {eng_r.sclS[0], sclIn};
      eng_nxt.sdaS = {eng_r.sdaS[0], sdaIn};
      // A target holding the clock low delays the high phase.
      stall = !eng_r.sclLow && !eng_r.sclS[1];
      tick  = !stall && (eng_r.qcnt == (eng_r.fast ? QMAX_FAST : QMAX_STD));
      if (eng_r.st != ENG_IDLE)
      begin
         eng_nxt.qcnt = tick ? '0 : (stall ? eng_r.qcnt : eng_r.qcnt + 1'b1);
         if (tick)
         begin
            eng_nxt.ph = eng_r.ph + 1'b1;
         end
      end
      case (eng_r.st)
         ENG_IDLE:
         begin
            if (cmdValid)
            begin
               eng_nxt.fast = fastMode;
               eng_nxt.qcnt = '0;
               eng_nxt.ph   = 2'd0;
               eng_nxt.bitN = 4'd0;
               case (cmd)
                  i2cbl_pkg::I2CBL_CMD_START:
                  begin
                     eng_nxt.st     = ENG_START;
                     eng_nxt.sdaLow = 1'b0;
                  end
                  i2cbl_pkg::I2CBL_CMD_STOP:
                  begin
                     eng_nxt.st     = ENG_STOP;
                     eng_nxt.sdaLow = 1'b1;
                  end
                  i2cbl_pkg::I2CBL_CMD_READ:
                  begin
                     eng_nxt.st     = ENG_BIT;
                     eng_nxt.sh     = {8'hFF, ackOut};
                     eng_nxt.sdaLow = 1'b0;
                  end
                  default:
                  begin
                     eng_nxt.st     = ENG_BIT;
                     eng_nxt.sh     = {txByte, 1'b1};
                     eng_nxt.sdaLow = !txByte[7];
                  end
               endcase
            end
         end
         ENG_START:
         begin
            // Works both from an idle bus and as a repeated start.
            if (tick)
            begin
               case (eng_r.ph)
                  2'd0: eng_nxt.sclLow = 1'b0;
                  2'd1: eng_nxt.sdaLow = 1'b1;
                  2'd2: eng_nxt.sclLow = 1'b1;
                  default:
                  begin
                     eng_nxt.st   = ENG_IDLE;
                     eng_nxt.done = 1'b1;
                  end
               endcase
            end
         end
         ENG_BIT:
         begin
            if (tick)
            begin
               case (eng_r.ph)
                  2'd0: eng_nxt.sclLow = 1'b0;
                  2'd1:
                  begin
                     if (eng_r.bitN == 4'd8)
                     begin
                        eng_nxt.ack = !eng_r.sdaS[1];
                     end
                     else
                     begin
                        eng_nxt.rx = {eng_r.rx[6:0], eng_r.sdaS[1]};
                     end
                  end
                  2'd2: eng_nxt.sclLow = 1'b1;
                  default:
                  begin
                     if (eng_r.bitN == 4'd8)
                     begin
                        eng_nxt.st     = ENG_IDLE;
                        eng_nxt.done   = 1'b1;
                        eng_nxt.sdaLow = 1'b0;
                     end
                     else
                     begin
                        eng_nxt.bitN   = eng_r.bitN + 1'b1;
                        eng_nxt.sh     = {eng_r.sh[7:0], 1'b1};
                        eng_nxt.sdaLow = !eng_r.sh[7];
                     end
                  end
               endcase
            end
         end
         ENG_STOP:
         begin
            if (tick)
            begin
               case (eng_r.ph)
                  2'd0: eng_nxt.sclLow = 1'b0;
                  2'd1: eng_nxt.sdaLow = 1'b0;
                  2'd2: eng_nxt.sclLow = 1'b0;
                  default:
                  begin
                     eng_nxt.st   = ENG_IDLE;
                     eng_nxt.done = 1'b1;
                  end
               endcase
            end
         end
         default: eng_nxt.st = ENG_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         eng_r <= '{st: ENG_IDLE, sclS: 2'b11, sdaS: 2'b11, default: '0};
      end
      else
      begin
         eng_r <= eng_nxt;
      end
   end

   assign sclOe  = eng_r.sclLow;
   assign sdaOe  = eng_r.sdaLow;
   assign busy   = (eng_r.st != ENG_IDLE);
   assign done   = eng_r.done;
   assign rxByte = eng_r.rx;
   assign ackIn  = eng_r.ack;
endmodule
`default_nettype wire

/* File: rtl/i2cbl_boot_loader.sv */
// Purpose: Power-up EEPROM probe and identity or boot image loader.
// Assumes: EEPROM answers at device address A0/A1 with a 16-bit pointer.
// Notes:   The processor is held until the load has finished.
//
// Behaviour
// - Bus master only, 100 or 400 kHz.
// - Probe at power-up; accept signature C0 or C2.
// - C0 loads identifiers in place of internal.
// - C2 copies EEPROM image into code RAM.
// - No EEPROM answers: use internal identifiers.
// - Internal release low three digits give revision.
// - USB runs at full speed only.
`default_nettype none
module i2cbl_boot_loader
#(
   parameter logic [15:0] DEF_VENDOR_ID  = 16'h1234, // Arbitrary value.
   parameter logic [15:0] DEF_PRODUCT_ID = 16'h5678, // Arbitrary value.
   parameter logic [3:0]  DEF_REL_TOP    = 4'h5,     // Arbitrary value.
   parameter logic [11:0] SILICON_REV    = 12'h001
)
(
   input  wire logic                          clk,
   input  wire logic                          resetn,
   input  wire logic                          fastMode,
   input  wire logic                          sclIn,
   input  wire logic                          sdaIn,
   output logic                               sclOut,
   output logic                               sclOe,
   output logic                               sdaOut,
   output logic                               sdaOe,
   output logic [15:0]                        vendorId,
   output logic [15:0]                        productId,
   output logic [15:0]                        deviceRelease,
   output i2cbl_pkg::i2cbl_src_type           bootSource,
   output logic                               bootDone,
   output logic                               cpuHold,
   output logic                               ramWe,
   output logic [i2cbl_pkg::RAM_AW-1:0]       ramAddr,
   output logic [7:0]                         ramData,
   output logic                               usbFullSpeed
);
   typedef enum logic [3:0] {
      BT_START,
      BT_DEVW,
      BT_AHI,
      BT_ALO,
      BT_RSTART,
      BT_DEVR,
      BT_READ,
      BT_LAST,
      BT_STOP,
      BT_DONE
   } i2cbl_boot_state_type;

   typedef enum logic [2:0] {
      PART_HDR,
      PART_LENH,
      PART_LENL,
      PART_ADRH,
      PART_ADRL,
      PART_DATA
   } i2cbl_part_type;

   typedef struct packed {
      i2cbl_boot_state_type      st;
      i2cbl_part_type            part;
      logic                      issued;
      logic                      fail;
      logic [15:0]               idx;
      logic [7:0]                sig;
      logic [15:0]               eeVid;
      logic [15:0]               eePid;
      logic [15:0]               eeDid;
      logic [15:0]               recLen;
      logic [15:0]               recAddr;
      logic [15:0]               vid;
      logic [15:0]               pid;
      logic [15:0]               did;
      i2cbl_pkg::i2cbl_src_type  src;
      logic                      done;
      logic                      hold;
      logic                      we;
      logic [i2cbl_pkg::RAM_AW-1:0] addr;
      logic [7:0]                data;
   } i2cbl_boot_type;

   localparam logic [15:0] DEF_RELEASE = {DEF_REL_TOP, SILICON_REV};

   i2cbl_boot_type boot_r;
   i2cbl_boot_type boot_nxt;

   logic                      cmdValid;
   i2cbl_pkg::i2cbl_cmd_type  cmd;
   logic [7:0]                txByte;
   logic                      ackOut;
   logic                      engBusy;
   logic                      engDone;
   logic [7:0]                rxByte;
   logic                      ackIn;

   i2cbl_bit_engine u_engine
   (
      .clk      (clk),
      .resetn   (resetn),
      .cmdValid (cmdValid),
      .cmd      (cmd),
      .txByte   (txByte),
      .ackOut   (ackOut),
      .fastMode (fastMode),
      .sclIn    (sclIn),
      .sdaIn    (sdaIn),
      .sclOe    (sclOe),
      .sdaOe    (sdaOe),
      .busy     (engBusy),
      .done     (engDone),
      .rxByte   (rxByte),
      .ackIn    (ackIn)
   );

   always_comb
   begin
      boot_nxt    = boot_r;
      boot_nxt.we = 1'b0;
      cmd         = i2cbl_pkg::I2CBL_CMD_WRITE;
      txByte      = 8'hFF;
      ackOut      = 1'b0;
      case (boot_r.st)
         BT_START, BT_RSTART: cmd = i2cbl_pkg::I2CBL_CMD_START;
         BT_DEVW:   txByte = i2cbl_pkg::DEV_WRITE;
         BT_AHI:    txByte = i2cbl_pkg::MEM_ADDR_HI;
         BT_ALO:    txByte = i2cbl_pkg::MEM_ADDR_LO;
         BT_DEVR:   txByte = i2cbl_pkg::DEV_READ;
         BT_READ:   cmd = i2cbl_pkg::I2CBL_CMD_READ;
         BT_LAST:
         begin
            // A final not-acknowledged read frees the bus for the stop.
            cmd    = i2cbl_pkg::I2CBL_CMD_READ;
            ackOut = 1'b1;
         end
         BT_STOP:   cmd = i2cbl_pkg::I2CBL_CMD_STOP;
         default:   cmd = i2cbl_pkg::I2CBL_CMD_WRITE;
      endcase
      cmdValid = (boot_r.st != BT_DONE) && !boot_r.issued && !engBusy;
      if (cmdValid)
      begin
         boot_nxt.issued = 1'b1;
      end
      if (engDone)
      begin
         boot_nxt.issued = 1'b0;
         case (boot_r.st)
            BT_START:  boot_nxt.st = BT_DEVW;
            BT_RSTART: boot_nxt.st = BT_DEVR;
            BT_DEVW, BT_AHI, BT_ALO, BT_DEVR:
            begin
               if (!ackIn)
               begin
                  boot_nxt.fail = 1'b1;
                  boot_nxt.st   = BT_STOP;
               end
               else if (boot_r.st == BT_DEVW)
               begin
                  boot_nxt.st = BT_AHI;
               end
               else if (boot_r.st == BT_AHI)
               begin
                  boot_nxt.st = BT_ALO;
               end
               else if (boot_r.st == BT_ALO)
               begin
                  boot_nxt.st = BT_RSTART;
               end
               else
               begin
                  boot_nxt.st = BT_READ;
               end
            end
            BT_READ:
            begin
               boot_nxt.idx = boot_r.idx + 1'b1;
               case (boot_r.part)
                  PART_HDR:
                  begin
                     case (boot_r.idx)
                        i2cbl_pkg::IDX_SIG:
                        begin
                           boot_nxt.sig = rxByte;
                           if (rxByte != i2cbl_pkg::SIG_IDS &&
                               rxByte != i2cbl_pkg::SIG_IMAGE)
                           begin
                              boot_nxt.fail = 1'b1;
                              boot_nxt.st   = BT_LAST;
                           end
                        end
                        i2cbl_pkg::IDX_VID_LO: boot_nxt.eeVid[7:0]  = rxByte;
                        i2cbl_pkg::IDX_VID_HI: boot_nxt.eeVid[15:8] = rxByte;
                        i2cbl_pkg::IDX_PID_LO: boot_nxt.eePid[7:0]  = rxByte;
                        i2cbl_pkg::IDX_PID_HI: boot_nxt.eePid[15:8] = rxByte;
                        i2cbl_pkg::IDX_DID_LO: boot_nxt.eeDid[7:0]  = rxByte;
                        i2cbl_pkg::IDX_DID_HI: boot_nxt.eeDid[15:8] = rxByte;
                        default:
                        begin
                           // The configuration byte closes the header.
                           if (boot_r.sig == i2cbl_pkg::SIG_IDS)
                           begin
                              boot_nxt.st = BT_LAST;
                           end
                           else
                           begin
                              boot_nxt.part = PART_LENH;
                           end
                        end
                     endcase
                  end
                  PART_LENH:
                  begin
                     boot_nxt.recLen[15:8] = rxByte;
                     boot_nxt.part = PART_LENL;
                     if (rxByte[i2cbl_pkg::END_MARK_BIT])
                     begin
                        boot_nxt.st = BT_LAST;
                     end
                  end
                  PART_LENL:
                  begin
                     boot_nxt.recLen[7:0] = rxByte;
                     boot_nxt.part = PART_ADRH;
                  end
                  PART_ADRH:
                  begin
                     boot_nxt.recAddr[15:8] = rxByte;
                     boot_nxt.part = PART_ADRL;
                  end
                  PART_ADRL:
                  begin
                     boot_nxt.recAddr[7:0] = rxByte;
                     boot_nxt.part = (boot_r.recLen == 16'h0000) ?
                                     PART_LENH : PART_DATA;
                  end
                  default:
                  begin
                     boot_nxt.we   = 1'b1;
                     boot_nxt.addr = boot_r.recAddr[i2cbl_pkg::RAM_AW-1:0];
                     boot_nxt.data = rxByte;
                     boot_nxt.recAddr = boot_r.recAddr + 1'b1;
                     boot_nxt.recLen  = boot_r.recLen - 1'b1;
                     if (boot_r.recLen == 16'h0001)
                     begin
                        boot_nxt.part = PART_LENH;
                     end
                  end
               endcase
            end
            BT_LAST: boot_nxt.st = BT_STOP;
            BT_STOP:
            begin
               boot_nxt.st   = BT_DONE;
               boot_nxt.done = 1'b1;
               boot_nxt.hold = 1'b0;
               if (boot_r.fail)
               begin
                  boot_nxt.src = i2cbl_pkg::I2CBL_SRC_NONE;
               end
               else
               begin
                  boot_nxt.vid = boot_r.eeVid;
                  boot_nxt.pid = boot_r.eePid;
                  boot_nxt.did = boot_r.eeDid;
                  boot_nxt.src = (boot_r.sig == i2cbl_pkg::SIG_IDS) ?
                                 i2cbl_pkg::I2CBL_SRC_IDS :
                                 i2cbl_pkg::I2CBL_SRC_IMAGE;
               end
            end
            default: boot_nxt.st = BT_DONE;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         boot_r <= '{st: BT_START, part: PART_HDR,
                     vid: DEF_VENDOR_ID, pid: DEF_PRODUCT_ID, hold: 1'b1,
                     did: DEF_RELEASE, src: i2cbl_pkg::I2CBL_SRC_NONE,
                     default: '0};
      end
      else
      begin
         boot_r <= boot_nxt;
      end
   end

   // The wires are only ever pulled low; no target logic exists here.
   assign sclOut        = 1'b0;
   assign sdaOut        = 1'b0;
   assign vendorId      = boot_r.vid;
   assign productId     = boot_r.pid;
   assign deviceRelease = boot_r.did;
   assign bootSource    = boot_r.src;
   assign bootDone      = boot_r.done;
   assign cpuHold       = boot_r.hold;
   assign ramWe         = boot_r.we;
   assign ramAddr       = boot_r.addr;
   assign ramData       = boot_r.data;
   assign usbFullSpeed  = 1'b1;
endmodule
`default_nettype wire

/* File: test/i2cbl_properties.sv */
// Purpose: Port checks of the two-wire boot loader.
// Assumes: Identity parameters match those of the bound loader.
// Notes:   Bound to every loader instance.
`default_nettype none
module i2cbl_properties
#(
   parameter logic [15:0] DEF_VENDOR_ID  = 16'h1234,
   parameter logic [15:0] DEF_PRODUCT_ID = 16'h5678,
   parameter logic [3:0]  DEF_REL_TOP    = 4'h5,
   parameter logic [11:0] SILICON_REV    = 12'h001
)
(
   input wire logic                     clk,
   input wire logic                     resetn,
   input wire logic                     sclOut,
   input wire logic                     sdaOut,
   input wire logic [15:0]              vendorId,
   input wire logic [15:0]              productId,
   input wire logic [15:0]              deviceRelease,
   input wire i2cbl_pkg::i2cbl_src_type bootSource,
   input wire logic                     bootDone,
   input wire logic                     cpuHold,
   input wire logic                     ramWe,
   input wire logic                     usbFullSpeed
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   AST_OPEN_DRAIN: assert property (!sclOut && !sdaOut)
      else $error("A bus pin is driven high.");
   AST_FULL_SPEED: assert property (usbFullSpeed == 1'b1)
      else $error("Full speed flag is low.");
   AST_DONE_STAYS: assert property (bootDone |=> bootDone)
      else $error("Boot done dropped.");
   AST_SRC_LEGAL: assert property (bootDone |-> bootSource inside
      {i2cbl_pkg::I2CBL_SRC_NONE, i2cbl_pkg::I2CBL_SRC_IDS,
       i2cbl_pkg::I2CBL_SRC_IMAGE})
      else $error("Boot source holds an unused code.");
   AST_WE_IN_BOOT: assert property (ramWe |-> cpuHold && !bootDone)
      else $error("Image write outside the boot phase.");
   AST_WE_PULSE: assert property (ramWe |=> !ramWe)
      else $error("Image write strobe longer than one cycle.");
   AST_DEFAULT_IDS: assert property (bootDone &&
      bootSource == i2cbl_pkg::I2CBL_SRC_NONE |-> vendorId == DEF_VENDOR_ID
      && productId == DEF_PRODUCT_ID)
      else $error("Internal identifiers not used.");
   AST_REVISION: assert property (!bootDone ||
      bootSource == i2cbl_pkg::I2CBL_SRC_NONE |->
      deviceRelease == {DEF_REL_TOP, SILICON_REV})
      else $error("Internal release value is wrong.");
   AST_IDS_STABLE: assert property (bootDone |=> $stable(vendorId)
      && $stable(productId) && $stable(deviceRelease))
      else $error("Identifiers changed after boot.");
endmodule

bind i2cbl_boot_loader i2cbl_properties #(
   .DEF_VENDOR_ID(DEF_VENDOR_ID), .DEF_PRODUCT_ID(DEF_PRODUCT_ID),
   .DEF_REL_TOP(DEF_REL_TOP), .SILICON_REV(SILICON_REV)) props (
   .clk(clk), .resetn(resetn), .sclOut(sclOut), .sdaOut(sdaOut),
   .vendorId(vendorId), .productId(productId),
   .deviceRelease(deviceRelease), .bootSource(bootSource),
   .bootDone(bootDone), .cpuHold(cpuHold), .ramWe(ramWe),
   .usbFullSpeed(usbFullSpeed));
`default_nettype wire

/* File: test/i2cbl_eeprom_model.sv */
// Purpose: Behavioural serial EEPROM on the two-wire bus.
// Assumes: Device address A0/A1 and a 16-bit pointer; no clock stretch.
// Notes:   Only the low pointer byte selects; writes are ignored.
`default_nettype none
module i2cbl_eeprom_model
(
   input  wire logic scl,
   input  wire logic sda,
   input  wire logic present,
   output logic      sdaOe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0]  mem [256];
   logic [7:0]  sh = 8'h00;
   logic [15:0] ptr = 16'h0000;
   logic        rd = 1'b0;
   int          bitCnt = 0;
   int          phase = -1;
   initial
   begin
      sdaOe = 1'b0;
      foreach (mem[i])
         mem[i] = 8'hFF;
   end
   always @(negedge sda)
      if (scl)
      begin
         bitCnt = 0;
         phase = 0;
         rd = 1'b0;
      end
   always @(posedge sda)
      if (scl)
         phase = -1;
   // A master NACK ends the read, as on a real part.
   always @(posedge scl)
   begin
      if (bitCnt < 8)
         sh = {sh[6:0], sda};
      else if (rd && sda)
         phase = -1;
      bitCnt = bitCnt + 1;
   end
   always @(negedge scl)
   begin
      sdaOe = 1'b0;
      if (bitCnt == 9)
         bitCnt = 0;
      if (phase < 0)
         rd = 1'b0;
      else if (rd && bitCnt < 8)
         sdaOe = !mem[ptr[7:0]][7 - bitCnt];
      else if (rd && bitCnt == 8)
         ptr = ptr + 16'h0001;
      else if (bitCnt == 8)
      begin
         sdaOe = phase > 0 || (present && sh[7:1] == 7'h50);
         if (phase == 0)
            rd = sh[0];
         if (phase == 1)
            ptr[15:8] = sh;
         if (phase == 2)
            ptr[7:0] = sh;
         phase = sdaOe ? phase + 1 : -1;
      end
   end
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// Purpose: Self-checking bench of the two-wire boot loader.
// Assumes: Pull-ups on both wires; only the loader drives SCL.
// Notes:   Fast rate throughout except one standard-rate probe.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic fastMode = 1'b0;
   logic present = 1'b0;
   int error_cnt = 0;
   int total_checks = 0;
   logic sclOut, sclOe, sdaOut, sdaOe, ramWe, bootDone, cpuHold, usbFs;
   logic memOe;
   logic [15:0] vid, pid, did;
   i2cbl_pkg::i2cbl_src_type src;
   logic [13:0] ramAddr;
   logic [7:0] ramData;
   logic [13:0] wrA [$];
   logic [7:0] wrD [$];
   wire logic sclW = !sclOe;
   wire logic sdaW = !(sdaOe || memOe);
   always #5 clk = ~clk;
   // Identity values below are arbitrary.
   i2cbl_boot_loader #(.DEF_VENDOR_ID(16'h2468), .DEF_PRODUCT_ID(16'h1357),
      .DEF_REL_TOP(4'h9), .SILICON_REV(12'h001)) DUT
   (.clk(clk), .resetn(resetn), .fastMode(fastMode), .sclIn(sclW),
    .sdaIn(sdaW), .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .vendorId(vid), .productId(pid), .deviceRelease(did),
    .bootSource(src), .bootDone(bootDone), .cpuHold(cpuHold),
    .ramWe(ramWe), .ramAddr(ramAddr), .ramData(ramData),
    .usbFullSpeed(usbFs));
   i2cbl_eeprom_model eeprom
   (.scl(sclW), .sda(sdaW), .present(present), .sdaOe(memOe));
   always @(posedge clk)
      if (ramWe === 1'b1)
      begin
         wrA.push_back(ramAddr);
         wrD.push_back(ramData);
      end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                        input string what);
      total_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask
   task automatic close_out();
      $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic load(input logic [7:0] img [$]);
      foreach (img[i])
         eeprom.mem[i] = img[i];
   endtask
   task automatic start(input logic fast, input logic here);
      @(posedge clk);
      #1 resetn = 1'b0;
      fastMode = fast;
      present = here;
      repeat (12) @(posedge clk);
      wrA.delete();
      wrD.delete();
      #1 resetn = 1'b1;
   endtask
   // A stretch stall after each release may add a few cycles per bit.
   task automatic measure(input int qtr);
      realtime t0;
      int per;
      @(posedge sclW);
      t0 = $realtime;
      @(posedge sclW);
      per = int'(($realtime - t0) / 10.0);
      check(16'(per >= 4 * qtr && per <= 4 * qtr + 4), 16'h0001, "rate");
   endtask
   task automatic finish_boot(input logic [15:0] v, p, d,
                              input logic [1:0] s);
      int n = 0;
      while (bootDone !== 1'b1 && n < 80000)
      begin
         @(posedge clk);
         n++;
      end
      #2;
      check(16'(bootDone), 16'h0001, "boot did not end");
      check(16'(cpuHold), 16'h0000, "processor still held");
      check(16'(src), 16'(s), "boot source");
      check(vid, v, "vendor id");
      check(pid, p, "product id");
      check(did, d, "release");
      check(16'(usbFs), 16'h0001, "speed flag");
   endtask
   task automatic test_absent();
      start(1'b0, 1'b0);
      measure(i2cbl_pkg::QTR_STD);
      finish_boot(16'h2468, 16'h1357, 16'h9001, 2'h0);
      check(16'(wrA.size()), 16'h0000, "image writes");
      $display("Test absent done");
   endtask
   task automatic test_bad();
      load('{8'h55, 8'h11, 8'h22});
      start(1'b1, 1'b1);
      finish_boot(16'h2468, 16'h1357, 16'h9001, 2'h0);
      check(16'(wrA.size()), 16'h0000, "image writes");
      $display("Test bad signature done");
   endtask
   task automatic test_ids();
      load('{8'hC0, 8'hEF, 8'hBE, 8'hAD, 8'hDE, 8'h34, 8'h12, 8'h00});
      start(1'b1, 1'b1);
      measure(i2cbl_pkg::QTR_FAST);
      finish_boot(16'hBEEF, 16'hDEAD, 16'h1234, 2'h1);
      check(16'(wrA.size()), 16'h0000, "image writes");
      $display("Test identifiers done");
   endtask
   task automatic test_image();
      load('{8'hC2, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h00,
             8'h00, 8'h02, 8'h00, 8'h10, 8'hAA, 8'h55,
             8'h80, 8'h00, 8'h00, 8'h00});
      start(1'b1, 1'b1);
      finish_boot(16'h2211, 16'h4433, 16'h6655, 2'h2);
      check(16'(wrA.size()), 16'h0002, "image length");
      check(16'(wrA[0]), 16'h0010, "first address");
      check(16'(wrD[0]), 16'h00AA, "first byte");
      check(16'(wrA[1]), 16'h0011, "second address");
      check(16'(wrD[1]), 16'h0055, "second byte");
      $display("Test image done");
   endtask
   initial
   begin
      test_absent();
      test_bad();
      test_ids();
      test_image();
      close_out();
   end
   initial
   begin
      #1_500_000;
      error_cnt++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      close_out();
   end
endmodule
`default_nettype wire
